// ===== hw/pbdc_pkg.sv
// Constants for the PC breakpoint and debug routine control block
package pbdc_pkg;
  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int PC_W = 24;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [15:0] IDX_CAP_L = 16'ha098;
  localparam logic [15:0] IDX_CAP_H = 16'ha099;
  localparam logic [15:0] IDX_CAP_T = 16'ha09a;
  localparam logic [15:0] IDX_NXT_L = 16'ha09b;
  localparam logic [15:0] IDX_NXT_H = 16'ha09c;
  localparam logic [15:0] IDX_NXT_T = 16'ha09d;
  localparam logic [15:0] IDX_STEP_KEY = 16'ha09e;
  localparam logic [15:0] IDX_BP_RSVD = 16'ha0e2;
  localparam logic [15:0] IDX_CTRL = 16'ha0e3;
  localparam logic [15:0] IDX_BP1_L = 16'ha0f0;
  localparam logic [15:0] IDX_BP1_H = 16'ha0f1;
  localparam logic [15:0] IDX_BP1_T = 16'ha0f2;
  localparam logic [15:0] IDX_BP2_L = 16'ha0f4;
  localparam logic [15:0] IDX_BP2_H = 16'ha0f5;
  localparam logic [15:0] IDX_BP2_T = 16'ha0f6;
  localparam logic [15:0] IDX_EVT_FLAG = 16'ha0f8;
  localparam logic [15:0] IDX_EVT_EN = 16'ha0f9;
  // ==========================================================
  // Control register fields and reset values
  localparam int CTRL_NEST = 7;
  localparam int CTRL_WDT = 6;
  localparam int CTRL_T2 = 5;
  localparam int CTRL_T1 = 4;
  localparam int CTRL_T0 = 3;
  localparam int CTRL_INR = 0;
  localparam logic [7:0] CTRL_RST = 8'hfc;
  localparam logic [7:0] CTRL_WMASK = 8'hf9;
  localparam logic [7:0] CTRL_ENTRY_CLR = 8'hf8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ==========================================================
  // Event flag and enable positions
  localparam int EVT_STEP = 7;
  localparam int EVT_PC2 = 1;
  localparam int EVT_PC1 = 0;
  // ==========================================================
  // Fixed values
  localparam logic [7:0] STEP_KEY = 8'h96;
  localparam logic [15:0] BP_VECTOR = 16'h7080;
endpackage

// ===== hw/pbdc_pc_cmp.sv
// Program counter compare against one breakpoint address
`timescale 1ns/1ps
`default_nettype none
module pbdc_pc_cmp (
  input wire logic [23:0] cmp_addr,
  input wire logic [23:0] fetch_pc,
  input wire logic fetch_valid,
  input wire logic cmp_enable,
  output logic hit
);
  // ==========================================================
  // Match only on a real fetch, so a stalled PC bus cannot fire
  assign hit = fetch_valid && cmp_enable && (fetch_pc == cmp_addr);
endmodule
`default_nettype wire

// ===== hw/pbdc_top.sv
// PC breakpoint and debug routine control with APB register slave
`timescale 1ns/1ps
`default_nettype none
module pbdc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_pc,
  input wire logic [23:0] exec_pc,
  input wire logic return_fetch,
  input wire logic debug_host_entry,
  input wire logic pc_match_entry,
  output logic nested_irq_allow,
  output logic watchdog_count_allow,
  output logic timer_two_count_allow,
  output logic timer_one_count_allow,
  output logic timer_zero_count_allow,
  output logic in_debug_routine,
  output logic single_step_active,
  output logic bp_irq,
  output logic [15:0] bp_irq_vector
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] ctrl;
    logic [23:0] bp1;
    logic [23:0] bp2;
    logic [23:0] cap_pc;
    logic [23:0] nxt_pc;
    logic [7:0] key;
    logic step_on;
    logic [7:0] flags;
    logic [7:0] en;
    logic irq;
    logic [15:0] vector;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pbdc_state_s;

  localparam pbdc_state_s STATE_RST = '{
    ctrl: pbdc_pkg::CTRL_RST,
    bp1: 24'h000000,
    bp2: 24'h000000,
    cap_pc: 24'h000000,
    nxt_pc: 24'h000000,
    key: pbdc_pkg::BYTE_RST,
    step_on: 1'b0,
    flags: pbdc_pkg::BYTE_RST,
    en: pbdc_pkg::BYTE_RST,
    irq: 1'b0,
    vector: pbdc_pkg::BP_VECTOR,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h00000000
  };

  localparam logic [7:0] EVT_MASK = 8'h83;

  pbdc_state_s s_r;
  pbdc_state_s s_nxt;
  logic [15:0] widx;
  logic aligned;
  logic setup;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic hit1;
  logic hit2;
  logic bp_event;
  logic step_evt;
  logic entry;

  assign widx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup = psel && !penable;
  // Write lands only on the completing edge of the access phase
  assign wr_en = psel && penable && s_r.pready && pwrite && pstrb[0] && !s_r.pslverr;
  assign wbyte = pwdata[7:0];
  assign entry = debug_host_entry || pc_match_entry;

  // ==========================================================
  // Compare units
  // breakpoint one compare
  pbdc_pc_cmp u_cmp1 (
    .cmp_addr(s_r.bp1),
    .fetch_pc(fetch_pc),
    .fetch_valid(fetch_valid),
    .cmp_enable(s_r.en[pbdc_pkg::EVT_PC1]),
    .hit(hit1)
  );

  pbdc_pc_cmp u_cmp2 (
    .cmp_addr(s_r.bp2),
    .fetch_pc(fetch_pc),
    .fetch_valid(fetch_valid),
    .cmp_enable(s_r.en[pbdc_pkg::EVT_PC2]),
    .hit(hit2)
  );

  assign bp_event = hit1 || hit2;
  // step event on interrupt return fetch
  assign step_evt = fetch_valid && return_fetch && s_r.step_on;

  // ==========================================================
  // Read decode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = aligned;
    case (widx)
      pbdc_pkg::IDX_CAP_L: rd_byte = s_r.cap_pc[7:0];
      pbdc_pkg::IDX_CAP_H: rd_byte = s_r.cap_pc[15:8];
      pbdc_pkg::IDX_CAP_T: rd_byte = s_r.cap_pc[23:16];
      pbdc_pkg::IDX_NXT_L: rd_byte = s_r.nxt_pc[7:0];
      pbdc_pkg::IDX_NXT_H: rd_byte = s_r.nxt_pc[15:8];
      pbdc_pkg::IDX_NXT_T: rd_byte = s_r.nxt_pc[23:16];
      pbdc_pkg::IDX_STEP_KEY: rd_byte = s_r.key;
      pbdc_pkg::IDX_BP_RSVD: rd_byte = 8'h00;
      pbdc_pkg::IDX_CTRL: rd_byte = s_r.ctrl;
      pbdc_pkg::IDX_BP1_L: rd_byte = s_r.bp1[7:0];
      pbdc_pkg::IDX_BP1_H: rd_byte = s_r.bp1[15:8];
      pbdc_pkg::IDX_BP1_T: rd_byte = s_r.bp1[23:16];
      pbdc_pkg::IDX_BP2_L: rd_byte = s_r.bp2[7:0];
      pbdc_pkg::IDX_BP2_H: rd_byte = s_r.bp2[15:8];
      pbdc_pkg::IDX_BP2_T: rd_byte = s_r.bp2[23:16];
      pbdc_pkg::IDX_EVT_FLAG: rd_byte = s_r.flags;
      pbdc_pkg::IDX_EVT_EN: rd_byte = s_r.en;
      default: rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    if (setup) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !rd_hit;
      s_nxt.prdata = {24'h000000, rd_hit ? rd_byte : 8'h00};
    end else if (psel && penable && s_r.pready) begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end
    if (wr_en) begin
      case (widx)
        pbdc_pkg::IDX_STEP_KEY: s_nxt.key = wbyte;
        pbdc_pkg::IDX_CTRL: begin
          s_nxt.ctrl = (s_r.ctrl & ~pbdc_pkg::CTRL_WMASK) | (wbyte & pbdc_pkg::CTRL_WMASK);
        end
        pbdc_pkg::IDX_BP1_L: s_nxt.bp1[7:0] = wbyte;
        pbdc_pkg::IDX_BP1_H: s_nxt.bp1[15:8] = wbyte;
        pbdc_pkg::IDX_BP1_T: s_nxt.bp1[23:16] = wbyte;
        pbdc_pkg::IDX_BP2_L: s_nxt.bp2[7:0] = wbyte;
        pbdc_pkg::IDX_BP2_H: s_nxt.bp2[15:8] = wbyte;
        pbdc_pkg::IDX_BP2_T: s_nxt.bp2[23:16] = wbyte;
        pbdc_pkg::IDX_EVT_FLAG: s_nxt.flags = s_r.flags & ~(wbyte & EVT_MASK);
        pbdc_pkg::IDX_EVT_EN: s_nxt.en = wbyte & EVT_MASK;
        // captured bytes and reserved ignore writes
        default: s_nxt.key = s_nxt.key;
      endcase
    end
    // entry suspends interrupts and counting, beats a same-cycle write
    if (entry) begin
      s_nxt.ctrl = s_nxt.ctrl & ~pbdc_pkg::CTRL_ENTRY_CLR;
      // status set at entry, set wins over clear
      s_nxt.ctrl[pbdc_pkg::CTRL_INR] = 1'b1;
    end
    // hardware set wins over software clear
    if (hit1) begin
      s_nxt.flags[pbdc_pkg::EVT_PC1] = 1'b1;
    end
    if (hit2) begin
      s_nxt.flags[pbdc_pkg::EVT_PC2] = 1'b1;
    end
    if (step_evt) begin
      s_nxt.flags[pbdc_pkg::EVT_STEP] = 1'b1;
    end
    if (bp_event) begin
      s_nxt.cap_pc = exec_pc;
      s_nxt.nxt_pc = fetch_pc;
    end
    // only the exact key unlocks stepping
    s_nxt.step_on = (s_nxt.key == pbdc_pkg::STEP_KEY);
    s_nxt.irq = |(s_nxt.flags & s_nxt.en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign nested_irq_allow = s_r.ctrl[pbdc_pkg::CTRL_NEST];
  assign watchdog_count_allow = s_r.ctrl[pbdc_pkg::CTRL_WDT];
  assign timer_two_count_allow = s_r.ctrl[pbdc_pkg::CTRL_T2];
  assign timer_one_count_allow = s_r.ctrl[pbdc_pkg::CTRL_T1];
  assign timer_zero_count_allow = s_r.ctrl[pbdc_pkg::CTRL_T0];
  assign in_debug_routine = s_r.ctrl[pbdc_pkg::CTRL_INR];
  assign single_step_active = s_r.step_on;
  assign bp_irq = s_r.irq;
  assign bp_irq_vector = s_r.vector;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_ctrl;
  logic wr_key;
  assign wr_ctrl = wr_en && (widx == pbdc_pkg::IDX_CTRL);
  assign wr_key = wr_en && (widx == pbdc_pkg::IDX_STEP_KEY);

  property p_entry_suspend;
    entry |=> !watchdog_count_allow && !timer_zero_count_allow && !timer_one_count_allow
      && !timer_two_count_allow && !nested_irq_allow && in_debug_routine;
  endproperty
  a_entry_suspend: assert property (p_entry_suspend) else $error("entry kept counting on");

  property p_nest_rise;
    $rose(nested_irq_allow) |-> $past(wr_ctrl && wbyte[7] && !entry);
  endproperty
  a_nest_rise: assert property (p_nest_rise) else $error("nest enable rose without write");

  property p_wdt_rise;
    $rose(watchdog_count_allow) |-> $past(wr_ctrl && wbyte[6]);
  endproperty
  a_wdt_rise: assert property (p_wdt_rise) else $error("watchdog allow rose wrongly");

  property p_t2_fall;
    $fell(timer_two_count_allow) |-> $past(entry || (wr_ctrl && !wbyte[5]));
  endproperty
  a_t2_fall: assert property (p_t2_fall) else $error("timer two allow fell wrongly");

  property p_status_set;
    entry ##1 !entry |-> in_debug_routine && !nested_irq_allow;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set at entry");

  property p_bp1_write;
    wr_en && (widx == pbdc_pkg::IDX_BP1_T) |=> s_r.bp1[23:16] == $past(wbyte);
  endproperty
  a_bp1_write: assert property (p_bp1_write) else $error("bp1 top byte lost");

  property p_bp2_hit;
    fetch_valid && s_r.en[pbdc_pkg::EVT_PC2] && (fetch_pc == s_r.bp2)
      |=> s_r.flags[pbdc_pkg::EVT_PC2] ##1 1'b1;
  endproperty
  a_bp2_hit: assert property (p_bp2_hit) else $error("bp2 match missed");

  property p_cap;
    bp_event |=> s_r.cap_pc == $past(exec_pc) && s_r.nxt_pc == $past(fetch_pc);
  endproperty
  a_cap: assert property (p_cap) else $error("pc capture wrong");

  property p_cap_ro;
    !bp_event |=> $stable(s_r.cap_pc) && $stable(s_r.nxt_pc);
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("captured pc changed");

  property p_key_on;
    wr_key && (wbyte == pbdc_pkg::STEP_KEY) |=> single_step_active;
  endproperty
  a_key_on: assert property (p_key_on) else $error("key did not unlock");

  property p_key_off;
    wr_key && (wbyte != pbdc_pkg::STEP_KEY) |=> !single_step_active;
  endproperty
  a_key_off: assert property (p_key_off) else $error("bad key unlocked");

  property p_rsvd;
    setup && (widx == pbdc_pkg::IDX_BP_RSVD) && aligned |=> pready && prdata == 32'h0 && !pslverr;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved reads nonzero");

  property p_irq;
    bp_event ##1 s_r.en[pbdc_pkg::EVT_PC1] && s_r.en[pbdc_pkg::EVT_PC2]
      |-> bp_irq && bp_irq_vector == pbdc_pkg::BP_VECTOR;
  endproperty
  a_irq: assert property (p_irq) else $error("breakpoint irq missing");

  property p_step;
    step_evt |=> s_r.flags[pbdc_pkg::EVT_STEP] && (!s_r.en[pbdc_pkg::EVT_STEP] || bp_irq);
  endproperty
  a_step: assert property (p_step) else $error("step flag not set");

  c_entry: cover property (entry ##1 wr_ctrl);
  c_bp: cover property (bp_event ##1 bp_irq);
  c_step: cover property (step_evt);
  c_err: cover property (setup && !rd_hit);
endmodule
`default_nettype wire

// ===== bench/pbdc_cpu_model.sv
// Core-side stand-in: instruction fetch stream and routine entry pulses
`timescale 1ns/1ps
`default_nettype none
module pbdc_cpu_model (
  input wire logic pclk,
  output logic fetch_valid,
  output logic [23:0] fetch_pc,
  output logic [23:0] exec_pc,
  output logic return_fetch,
  output logic debug_host_entry,
  output logic pc_match_entry
);
  // ==========================================================
  // Idle levels
  initial begin
    fetch_valid = 1'h0;
    fetch_pc = 24'h000000;
    exec_pc = 24'h000000;
    return_fetch = 1'h0;
    debug_host_entry = 1'h0;
    pc_match_entry = 1'h0;
  end
  // ==========================================================
  // One fetch; idle address inverted so a stale match cannot pass
  task automatic fetch(input logic [23:0] pc, input logic [23:0] ex, input logic ret);
    @(posedge pclk);
    fetch_valid <= 1'h1;
    fetch_pc <= pc;
    exec_pc <= ex;
    return_fetch <= ret;
    @(posedge pclk);
    fetch_valid <= 1'h0;
    fetch_pc <= ~pc;
    exec_pc <= ~ex;
    return_fetch <= 1'h0;
  endtask
  // One-cycle entry pulse, host or breakpoint kind
  task automatic enter(input logic host);
    @(posedge pclk);
    debug_host_entry <= host;
    pc_match_entry <= ~host;
    @(posedge pclk);
    debug_host_entry <= 1'h0;
    pc_match_entry <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== bench/pbdc_top_bench.sv
// Self-checking bench for the breakpoint and debug control block
`timescale 1ns/1ps
`default_nettype none
module pbdc_top_bench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, fv, rf, dhe, pme;
  logic [23:0] fpc, epc;
  logic nia, wca, t2a, t1a, t0a, idr, ssa, irq;
  logic [15:0] vec;
  int failures = 0;
  int total_checks = 0;
  always #50 pclk = ~pclk;
  pbdc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch_valid(fv), .fetch_pc(fpc), .exec_pc(epc),
    .return_fetch(rf), .debug_host_entry(dhe), .pc_match_entry(pme),
    .nested_irq_allow(nia), .watchdog_count_allow(wca), .timer_two_count_allow(t2a),
    .timer_one_count_allow(t1a), .timer_zero_count_allow(t0a), .in_debug_routine(idr),
    .single_step_active(ssa), .bp_irq(irq), .bp_irq_vector(vec));
  pbdc_cpu_model cpu (.pclk(pclk), .fetch_valid(fv), .fetch_pc(fpc), .exec_pc(epc),
    .return_fetch(rf), .debug_host_entry(dhe), .pc_match_entry(pme));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered right after a rising edge; wait bounded, no latency assumed
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    if (pready !== 1'h1) begin
      failures++;
      $display("wrong value at %0t: no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'h1, {a, 2'h0}, d);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    apb(1'h0, {a, 2'h0}, 8'h00);
    chk(rd, {24'h000000, e});
  endtask
  task automatic wr24(input logic [15:0] a, input logic [23:0] v);
    wr(a, v[7:0]);
    wr(a + 16'h0001, v[15:8]);
    wr(a + 16'h0002, v[23:16]);
  endtask
  task automatic rd24(input logic [15:0] a, input logic [23:0] v);
    rchk(a, v[7:0]);
    rchk(a + 16'h0001, v[15:8]);
    rchk(a + 16'h0002, v[23:16]);
  endtask
  // Enables in control register bits 7 to 3, status in bit 2 (bit 0 in the register), step and irq in the low bits
  task automatic ochk(input logic [7:0] e);
    @(negedge pclk);
    chk({24'h000000, nia, wca, t2a, t1a, t0a, idr, ssa, irq}, {24'h000000, e});
    @(posedge pclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [15:0] idx [17] = '{pbdc_pkg::IDX_CAP_L, pbdc_pkg::IDX_CAP_H, pbdc_pkg::IDX_CAP_T,
      pbdc_pkg::IDX_NXT_L, pbdc_pkg::IDX_NXT_H, pbdc_pkg::IDX_NXT_T, pbdc_pkg::IDX_STEP_KEY,
      pbdc_pkg::IDX_BP_RSVD, pbdc_pkg::IDX_CTRL, pbdc_pkg::IDX_BP1_L, pbdc_pkg::IDX_BP1_H,
      pbdc_pkg::IDX_BP1_T, pbdc_pkg::IDX_BP2_L, pbdc_pkg::IDX_BP2_H, pbdc_pkg::IDX_BP2_T,
      pbdc_pkg::IDX_EVT_FLAG, pbdc_pkg::IDX_EVT_EN};
    ochk(8'hf8);
    chk({16'h0000, vec}, 32'h00007080);
    foreach (idx[i]) rchk(idx[i], (idx[i] == pbdc_pkg::IDX_CTRL) ? 8'hfc : 8'h00);
  endtask
  task automatic t_access();
    logic [15:0] a;
    for (int i = 0; i < 7; i++) begin
      a = (i == 6) ? pbdc_pkg::IDX_BP_RSVD : pbdc_pkg::IDX_CAP_L + 16'(i);
      wr(a, 8'hff);
      chk({31'h00000000, er}, 32'h00000000);
      rchk(a, 8'h00);
    end
    apb(1'h0, 18'h00000, 8'h00);
    chk({31'h00000000, er}, 32'h00000001);
    chk(rd, 32'h00000000);
    apb(1'h1, {pbdc_pkg::IDX_BP1_L, 2'h1}, 8'h55);
    chk({31'h00000000, er}, 32'h00000001);
    rchk(pbdc_pkg::IDX_BP1_L, 8'h00);
    pstrb <= 4'he;
    wr(pbdc_pkg::IDX_BP1_L, 8'h5a);
    pstrb <= 4'hf;
    chk({31'h00000000, er}, 32'h00000000);
    rchk(pbdc_pkg::IDX_BP1_L, 8'h00);
  endtask
  task automatic t_entry();
    for (int h = 0; h < 2; h++) begin
      wr(pbdc_pkg::IDX_CTRL, 8'hf8);
      cpu.enter(h[0]);
      ochk(8'h04);
      rchk(pbdc_pkg::IDX_CTRL, 8'h05);
      for (int k = 3; k < 8; k++) begin
        wr(pbdc_pkg::IDX_CTRL, 8'h01 | (8'h01 << k));
        ochk((8'h01 << k) | 8'h04);
      end
      wr(pbdc_pkg::IDX_CTRL, 8'hf8);
      ochk(8'hf8);
      rchk(pbdc_pkg::IDX_CTRL, 8'hfc);
    end
  endtask
  task automatic t_match();
    wr24(pbdc_pkg::IDX_BP1_L, 24'h123456);
    wr24(pbdc_pkg::IDX_BP2_L, 24'hfedcba);
    rd24(pbdc_pkg::IDX_BP1_L, 24'h123456);
    rd24(pbdc_pkg::IDX_BP2_L, 24'hfedcba);
    wr(pbdc_pkg::IDX_EVT_EN, 8'h83);
    cpu.fetch(24'h123457, 24'h123450, 1'h0);
    cpu.fetch(24'h023456, 24'h123450, 1'h0);
    rchk(pbdc_pkg::IDX_EVT_FLAG, 8'h00);
    cpu.fetch(24'h123456, 24'h12344f, 1'h0);
    ochk(8'hf9);
    rchk(pbdc_pkg::IDX_EVT_FLAG, 8'h01);
    rd24(pbdc_pkg::IDX_CAP_L, 24'h12344f);
    rd24(pbdc_pkg::IDX_NXT_L, 24'h123456);
    wr(pbdc_pkg::IDX_EVT_FLAG, 8'h01);
    cpu.fetch(24'hfedcba, 24'hfedcb8, 1'h0);
    rchk(pbdc_pkg::IDX_EVT_FLAG, 8'h02);
    rd24(pbdc_pkg::IDX_CAP_L, 24'hfedcb8);
    wr(pbdc_pkg::IDX_EVT_FLAG, 8'h02);
    wr(pbdc_pkg::IDX_EVT_EN, 8'h80);
    cpu.fetch(24'h123456, 24'h000000, 1'h0);
    ochk(8'hf8);
    rchk(pbdc_pkg::IDX_EVT_FLAG, 8'h00);
  endtask
  task automatic t_step();
    wr(pbdc_pkg::IDX_STEP_KEY, 8'h95);
    cpu.fetch(24'h000100, 24'h0000ff, 1'h1);
    ochk(8'hf8);
    rchk(pbdc_pkg::IDX_EVT_FLAG, 8'h00);
    wr(pbdc_pkg::IDX_STEP_KEY, pbdc_pkg::STEP_KEY);
    rchk(pbdc_pkg::IDX_STEP_KEY, 8'h96);
    cpu.fetch(24'h000101, 24'h000100, 1'h0);
    ochk(8'hfa);
    cpu.fetch(24'h000102, 24'h000101, 1'h1);
    cpu.fetch(24'h000103, 24'h000102, 1'h0);
    ochk(8'hfb);
    rchk(pbdc_pkg::IDX_EVT_FLAG, 8'h80);
    wr(pbdc_pkg::IDX_EVT_FLAG, 8'h80);
    wr(pbdc_pkg::IDX_STEP_KEY, 8'h00);
    ochk(8'hf8);
  endtask
  // Mid-run reset must drop key, status and captures
  task automatic t_rearm();
    wr(pbdc_pkg::IDX_STEP_KEY, pbdc_pkg::STEP_KEY);
    wr(pbdc_pkg::IDX_CTRL, 8'h01);
    ochk(8'h06);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    ochk(8'hf8);
    presetn <= 1'h1;
    @(posedge pclk);
    rd24(pbdc_pkg::IDX_CAP_L, 24'h000000);
    rd24(pbdc_pkg::IDX_BP1_L, 24'h000000);
    rchk(pbdc_pkg::IDX_STEP_KEY, 8'h00);
  endtask
  // ==========================================================
  // Verdict and run control
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_access();
    t_entry();
    t_match();
    t_step();
    t_rearm();
    finish_test();
  end
  // Run needs under four hundred cycles; twenty thousand means a hang
  initial begin
    #2000000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
